// ==== tfsr_pkg.sv ====
// constants for the tx frame statistics reporter
// assumes one 100 MHz clock and software access over APB
// Function
// - build 32-bit report, shift out serially
// - shift in step with tx client clocking
// - strobe qualifies every serial report bit
// - byte indicator high per transmitted frame byte
// - bits 28..20 zero in full duplex
// - bit 31 marks client requested pause frame
// - bits 28..25 hold attempts minus one
// - bit 23 collision on last 16 attempts
// - bit 22 late collision during frame
// - bit 21 deferral beyond maximum defer time
// - bit 20 frame was deferred at all
// - bit 19 vlan tag, only when enabled
// - bits 18..5 length, saturating at 16383
// - bit 4 length/type equals 88-08
// - bit 3 underrun during frame
// - bit 2 multicast destination address
// - bit 1 broadcast destination address
// - bit 0 frame sent without error
package tfsr_pkg;
  localparam int REPORT_BITS = 32;
  localparam logic [4:0] BIT_PAUSE = 5'h1F;
  localparam logic [4:0] BIT_ATT_LO = 5'h19;
  localparam logic [4:0] BIT_EXC_COLL = 5'h17;
  localparam logic [4:0] BIT_LATE_COLL = 5'h16;
  localparam logic [4:0] BIT_OVERLONG = 5'h15;
  localparam logic [4:0] BIT_DEFERRED = 5'h14;
  localparam logic [4:0] BIT_TAGGED = 5'h13;
  localparam logic [4:0] BIT_LEN_LO = 5'h05;
  localparam logic [4:0] BIT_CONTROL = 5'h04;
  localparam logic [4:0] BIT_UNDERRUN = 5'h03;
  localparam logic [4:0] BIT_MCAST = 5'h02;
  localparam logic [4:0] BIT_BCAST = 5'h01;
  localparam logic [4:0] BIT_SENT_OK = 5'h00;
  localparam logic [13:0] LEN_MAX = 14'h3FFF;
  localparam logic [15:0] TYPE_CONTROL = 16'h8808;
  localparam logic [15:0] TYPE_VLAN = 16'h8100;
  localparam logic [13:0] IDX_TYPE_HI = 14'h000C;
  localparam logic [13:0] IDX_TYPE_LO = 14'h000D;
  localparam logic [13:0] IDX_DA_LAST = 14'h0005;
  localparam logic [4:0] SHIFT_LAST = 5'h1F;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_LAST_REPORT = 12'h004;
  localparam logic [11:0] OFF_INT_STATUS = 12'h008;
  localparam logic [11:0] OFF_INT_ENABLE = 12'h00C;
  localparam logic [11:0] OFF_INT_CLEAR = 12'h010;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [2:0] INT_RESET = 3'h0;
  localparam logic [31:0] REPORT_RESET = 32'h0000_0000;
  typedef enum logic {SER_IDLE, SER_SHIFT} tfsr_ser_state_t;
endpackage : tfsr_pkg

// ==== tfsr_ser_if.sv ====
// carries a finished report from the collector to the serialiser
// assumes both ends share CLK_SYS
`timescale 1ns/10ps
interface tfsr_ser_if;
  logic load;
  logic [31:0] word;
  logic busy;
  logic done;
  modport src (output load, output word, input busy, input done);
  modport ser (input load, input word, output busy, output done);
endinterface : tfsr_ser_if

// ==== tfsr_serialiser.sv ====
// shifts one 32-bit report out, bit 0 first, under the strobe
// assumes load is only raised together with an active clock enable
`timescale 1ns/10ps
module tfsr_serialiser import tfsr_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // report hand-over
  tfsr_ser_if.ser ser,
  // serial pins
  output logic serial_out,
  output logic strobe
);
  tfsr_ser_state_t state_r;
  logic [31:0] shreg_r;
  logic [4:0] cnt_r;
  logic serial_r;
  logic strobe_r;
  logic done_r;
  wire start = ser.load && clk_en && (state_r == SER_IDLE);
  wire step = clk_en && (state_r == SER_SHIFT);
  wire last = step && (cnt_r == SHIFT_LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= SER_IDLE;
      cnt_r <= 5'h00;
    end else begin
      case (state_r)
        SER_IDLE: if (start) state_r <= SER_SHIFT;
        SER_SHIFT: if (last) state_r <= SER_IDLE;
        default: state_r <= SER_IDLE;
      endcase
      cnt_r <= start ? 5'h00 : (step ? cnt_r + 5'h01 : cnt_r);
    end
  end

  // moves only on enabled cycles so bits line up with the client signals
  always_ff @(posedge clk) begin
    if (srst) begin
      shreg_r <= REPORT_RESET;
      serial_r <= 1'b0;
      strobe_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= last;
      if (start) begin
        shreg_r <= ser.word;
        serial_r <= ser.word[0];
        strobe_r <= 1'b1;
      end else if (step) begin
        shreg_r <= {1'b0, shreg_r[31:1]};
        serial_r <= last ? 1'b0 : shreg_r[1];
        strobe_r <= !last;
      end
    end
  end

  assign ser.busy = (state_r != SER_IDLE);
  assign ser.done = done_r;
  assign serial_out = serial_r;
  assign strobe = strobe_r;
endmodule : tfsr_serialiser

// ==== tfsr_top.sv ====
// tx frame statistics reporter: builds a per-frame report and
// shifts it serially to the client; APB registers and interrupt
// assumes frame inputs come from the mac core, synchronous to CLK_SYS
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module tfsr_top import tfsr_pkg::*; (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // mac transmit side
  input wire logic TX_CLK_EN,
  input wire logic TX_BYTE_VALID,
  input wire logic [7:0] TX_BYTE,
  input wire logic TX_FRAME_DONE,
  input wire logic TX_PAUSE_GEN,
  input wire logic [3:0] TX_ATTEMPTS,
  input wire logic TX_EXC_COLL,
  input wire logic TX_LATE_COLL,
  input wire logic TX_OVERLONG_DEFER,
  input wire logic TX_DEFERRED,
  input wire logic TX_UNDERRUN,
  // client report pins
  output logic TX_REPORT_SERIAL_OUT,
  output logic TX_REPORT_STROBE,
  output logic TX_FRAME_BYTE_INDICATOR,
  // interrupt
  output logic IRQ
);
  tfsr_ser_if ser_if ();

  // apb decode
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  wire access = PSEL && PENABLE && !pready_r;
  wire hit_ctrl = (PADDR == OFF_CTRL);
  wire hit_last = (PADDR == OFF_LAST_REPORT);
  wire hit_stat = (PADDR == OFF_INT_STATUS);
  wire hit_en = (PADDR == OFF_INT_ENABLE);
  wire hit_clr = (PADDR == OFF_INT_CLEAR);
  wire mapped = hit_ctrl | hit_last | hit_stat | hit_en | hit_clr;
  // write lands on the completing edge, while the request is still held
  wire wr = PSEL && PENABLE && pready_r && PWRITE;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_en = wr && hit_en;
  wire wr_clr = wr && hit_clr;

  // control: bit0 full duplex, bit1 tx vlan handling
  logic [1:0] ctrl_r;
  wire full_duplex = ctrl_r[0];
  wire vlan_en = ctrl_r[1];

  // frame observation
  wire byte_ev = TX_BYTE_VALID && TX_CLK_EN;
  wire done_ev = TX_FRAME_DONE && TX_CLK_EN;
  logic [13:0] len_r;
  logic [13:0] len_nxt;
  logic mcast_r;
  logic bcast_r;
  logic [7:0] type_hi_r;
  logic [15:0] type_r;
  logic byte_ind_r;
  wire len_sat = (len_r == LEN_MAX);
  wire in_da = (len_r <= IDX_DA_LAST);
  wire is_control = (type_r == TYPE_CONTROL);
  wire is_tagged = vlan_en && (type_r == TYPE_VLAN);
  assign len_nxt = len_sat ? len_r : len_r + 14'h0001;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      len_r <= 14'h0000;
      mcast_r <= 1'b0;
      bcast_r <= 1'b1;
      type_hi_r <= 8'h00;
      type_r <= 16'h0000;
    end else if (done_ev) begin
      len_r <= 14'h0000;
      bcast_r <= 1'b1;
      mcast_r <= 1'b0;
      type_r <= 16'h0000;
    end else if (byte_ev) begin
      len_r <= len_nxt;
      if (len_r == 14'h0000) mcast_r <= TX_BYTE[0];
      if (in_da && TX_BYTE != 8'hFF) bcast_r <= 1'b0;
      if (len_r == IDX_TYPE_HI) type_hi_r <= TX_BYTE;
      if (len_r == IDX_TYPE_LO) type_r <= {type_hi_r, TX_BYTE};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) byte_ind_r <= 1'b0;
    else byte_ind_r <= byte_ev;
  end

  // report assembly
  logic [31:0] report_nxt;
  wire sent_ok = !(TX_UNDERRUN | TX_LATE_COLL | TX_EXC_COLL | TX_OVERLONG_DEFER);
  wire half = !full_duplex;
  always_comb begin
    report_nxt = REPORT_RESET;
    report_nxt[BIT_PAUSE] = TX_PAUSE_GEN;
    report_nxt[BIT_ATT_LO +: 4] = half ? TX_ATTEMPTS : 4'h0;
    report_nxt[BIT_EXC_COLL] = half && TX_EXC_COLL;
    report_nxt[BIT_LATE_COLL] = half && TX_LATE_COLL;
    report_nxt[BIT_OVERLONG] = half && TX_OVERLONG_DEFER;
    report_nxt[BIT_DEFERRED] = half && TX_DEFERRED;
    report_nxt[BIT_TAGGED] = is_tagged;
    report_nxt[BIT_LEN_LO +: 14] = len_r;
    report_nxt[BIT_CONTROL] = is_control;
    report_nxt[BIT_UNDERRUN] = TX_UNDERRUN;
    report_nxt[BIT_MCAST] = mcast_r;
    report_nxt[BIT_BCAST] = bcast_r && (len_r > IDX_DA_LAST);
    report_nxt[BIT_SENT_OK] = sent_ok;
  end

  // one report may wait while the previous one is still shifting;
  // a third frame before that overwrites it and flags an overrun
  logic [31:0] report_r;
  logic pending_r;
  wire load = pending_r && !ser_if.busy && TX_CLK_EN;
  wire overrun_ev = done_ev && pending_r && !load;
  assign ser_if.load = load;
  assign ser_if.word = report_r;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      report_r <= REPORT_RESET;
      pending_r <= 1'b0;
    end else begin
      if (done_ev) report_r <= report_nxt;
      pending_r <= done_ev || (pending_r && !load);
    end
  end

  tfsr_serialiser u_ser (
    .clk(CLK_SYS),
    .srst(SRST),
    .clk_en(TX_CLK_EN),
    .ser(ser_if),
    .serial_out(TX_REPORT_SERIAL_OUT),
    .strobe(TX_REPORT_STROBE)
  );

  // interrupt: bit0 report sent, bit1 underrun frame, bit2 report overrun
  logic [2:0] int_stat_r;
  logic [2:0] int_en_r;
  logic irq_r;
  wire [2:0] int_ev = {overrun_ev, done_ev && TX_UNDERRUN, ser_if.done};
  wire [2:0] int_clr = wr_clr ? PWDATA[2:0] : 3'h0;
  // set beats clear so no event is lost
  wire [2:0] int_stat_nxt = (int_stat_r & ~int_clr) | int_ev;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_r <= CTRL_RESET;
      int_stat_r <= INT_RESET;
      int_en_r <= INT_RESET;
      irq_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_r <= PWDATA[1:0];
      if (wr_en) int_en_r <= PWDATA[2:0];
      int_stat_r <= int_stat_nxt;
      irq_r <= |(int_stat_r & int_en_r);
    end
  end

  // read mux
  wire [31:0] rd_data = hit_ctrl ? {30'h0, ctrl_r} :
                        hit_last ? report_r :
                        hit_stat ? {29'h0, int_stat_r} :
                        hit_en ? {29'h0, int_en_r} : 32'h0000_0000;

  // answer on the second access cycle; unmapped addresses get pslverr
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access;
      pslverr_r <= access && !mapped;
      if (access && !PWRITE) prdata_r <= rd_data;
    end
  end

  assign PREADY = pready_r;
  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;
  assign TX_FRAME_BYTE_INDICATOR = byte_ind_r;
  assign IRQ = irq_r;

  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  logic [6:0] bits_h;
  logic dup_h;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      bits_h <= 7'h00;
      dup_h <= 1'b0;
    end else begin
      bits_h <= (load ? 7'h00 : bits_h) + {6'h00, TX_REPORT_STROBE && TX_CLK_EN};
      dup_h <= done_ev ? full_duplex : dup_h;
    end
  end

  a_report_bit_count: assert property ($fell(TX_REPORT_STROBE) |-> bits_h == 7'h20)
    else $error("report strobe did not cover 32 bits");
  a_strobe_on_load: assert property (load |=> TX_REPORT_STROBE && TX_REPORT_SERIAL_OUT == $past(report_r[0]))
    else $error("strobe or first bit wrong after load");
  a_strobe_frozen: assert property (TX_REPORT_STROBE && !TX_CLK_EN && !$past(load) |=> $stable(TX_REPORT_SERIAL_OUT))
    else $error("serial bit moved without clock enable");
  a_byte_indicator: assert property (TX_BYTE_VALID && TX_CLK_EN |=> TX_FRAME_BYTE_INDICATOR)
    else $error("byte indicator missing for a frame byte");
  a_full_duplex_zero: assert property (dup_h && $past(done_ev) |-> report_r[28:20] == 9'h000)
    else $error("half duplex bits set in full duplex");
  a_pause_flag: assert property (done_ev |=> report_r[31] == $past(TX_PAUSE_GEN))
    else $error("pause flag mismatch");
  a_attempts_copy: assert property (done_ev && !full_duplex |=> report_r[28:25] == $past(TX_ATTEMPTS))
    else $error("attempt count mismatch");
  a_reserved_zero: assert property (report_r[30:29] == 2'h0 && !report_r[24])
    else $error("reserved report bit set");
  a_length_field: assert property (done_ev |=> report_r[18:5] == $past(len_r))
    else $error("length field mismatch");
  a_control_type: assert property (done_ev && type_r == TYPE_CONTROL |=> report_r[4])
    else $error("control frame not flagged");
  a_sent_ok: assert property (done_ev && TX_UNDERRUN |=> !report_r[0] && report_r[3])
    else $error("underrun frame reported as good");

  c_report_shift: cover property (load ##1 TX_REPORT_STROBE [*8]);
  c_pending_wait: cover property (done_ev && ser_if.busy);
  c_irq_raise: cover property ($rose(IRQ));
endmodule : tfsr_top

// ==== tfsr_client_model.sv ====
// client-side model: collects the serial report while the strobe is high
// assumes the report pins and clock enable of tfsr_top
`timescale 1ns/10ps
module tfsr_client_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // report pins
  input wire logic serial_in,
  input wire logic strobe,
  // collected word
  output logic [31:0] word,
  output logic got
);
  logic [5:0] cnt_r;
  // bits outside the strobe are ignored, never shifted
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 6'h00;
      word <= 32'h0000_0000;
      got <= 1'b0;
    end else begin
      got <= 1'b0;
      if (clk_en && strobe) begin
        // bit 0 arrives first, so shift in from the top
        word <= {serial_in, word[31:1]};
        cnt_r <= cnt_r + 6'h01;
        got <= (cnt_r == 6'h1F);
      end else if (!strobe) begin
        cnt_r <= 6'h00;
      end
    end
  end
endmodule : tfsr_client_model

// ==== tx_frame_statistics_reporter_tb.sv ====
// self-checking bench for tfsr_top with the client model on the report pins
// assumes clock enable high, toggled while one report shifts
`timescale 1ns/10ps
module tx_frame_statistics_reporter_tb;
  import tfsr_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cw;
  logic bv, done, pg, exc, late, over, dfr, und, so, stb, ind, got, er, ce;
  logic [7:0] tb_byte;
  logic [3:0] att;
  int failures = 0, n_tests = 0;
  tfsr_top DUT (.CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TX_CLK_EN(ce), .TX_BYTE_VALID(bv), .TX_BYTE(tb_byte),
    .TX_FRAME_DONE(done), .TX_PAUSE_GEN(pg), .TX_ATTEMPTS(att), .TX_EXC_COLL(exc),
    .TX_LATE_COLL(late), .TX_OVERLONG_DEFER(over), .TX_DEFERRED(dfr), .TX_UNDERRUN(und),
    .TX_REPORT_SERIAL_OUT(so), .TX_REPORT_STROBE(stb), .TX_FRAME_BYTE_INDICATOR(ind), .IRQ(irq));
  tfsr_client_model client (.clk(clk), .srst(srst), .clk_en(ce), .serial_in(so),
    .strobe(stb), .word(cw), .got(got));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; waits for pready with a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      failures++;
      $display("[ERR] %0t apb transfer timed out", $time);
      disable run_all;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this step
    @(posedge clk);
  endtask : apb
  // res = pause, attempts[3:0], excessive, late, overlong, deferred, underrun
  task frame(input logic [7:0] d0, input logic bc, input logic [15:0] ty, input int n,
    input logic [9:0] res, input logic [31:0] exp, input logic slow);
    int i;
    for (i = 0; i < n; i++) begin
      bv <= 1'b1;
      tb_byte <= (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0] : (i < 6 && bc) ? 8'hFF :
        (i == 0) ? d0 : 8'h00;
      @(posedge clk);
      if (i == 2) chk({31'h0, ind}, 32'h1);
    end
    bv <= 1'b0;
    done <= 1'b1;
    {pg, att, exc, late, over, dfr, und} <= res;
    @(posedge clk);
    done <= 1'b0;
    chk({31'h0, ind}, 32'h1);
    @(posedge clk);
    chk({31'h0, ind}, 32'h0);
    for (i = 0; i < 200; i++) begin
      ce <= slow ? ~ce : 1'b1;
      @(posedge clk);
      if (got === 1'b1) break;
    end
    ce <= 1'b1;
    if (i == 200) begin
      failures++;
      $display("[ERR] %0t report never collected", $time);
      disable run_all;
    end
    chk(cw, exp);
  endtask : frame
  // half duplex broadcast control frame, late collision, deferrals
  task t_half;
    frame(8'hFF, 1'b1, TYPE_CONTROL, 64, 10'b0_0101_0_1_1_1_0, 32'h0A70_0816, 1'b1);
    repeat (3) @(posedge clk);
    apb(1'b0, OFF_LAST_REPORT, 32'h0);
    chk(rd, 32'h0A70_0816);
    $display("t_half done");
  endtask : t_half
  // pause frame, 16 colliding attempts, underrun; vlan type while vlan off; irq
  task t_err;
    apb(1'b1, OFF_INT_ENABLE, 32'h0000_0002);
    frame(8'h01, 1'b0, TYPE_VLAN, 100, 10'b1_1111_1_0_0_0_1, 32'h9E80_0C8C, 1'b0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFF_LAST_REPORT, 32'h0);
    chk(rd, 32'h9E80_0C8C);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b1, OFF_INT_CLEAR, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("t_err done");
  endtask : t_err
  // three reports in quick succession: the third overwrites the waiting one
  task t_over;
    int j;
    und <= 1'b0;
    apb(1'b1, OFF_INT_CLEAR, 32'h0000_0007);
    for (j = 0; j < 3; j++) begin
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      @(posedge clk);
    end
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    chk(rd, 32'h0000_0004);
    // drain both queued reports before the next frame is watched
    repeat (100) @(posedge clk);
    $display("t_over done");
  endtask : t_over
  // full duplex with vlan on: half-duplex bits cleared, length saturates
  task t_full;
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    frame(8'h02, 1'b0, TYPE_VLAN, 16390, 10'b1_1001_0_0_0_1_0, 32'h800F_FFE1, 1'b0);
    $display("t_full done");
  endtask : t_full
  initial begin
    {srst, psel, penable, pwrite, bv, done, pg, exc, late, over, dfr, und} = 12'h800;
    {paddr, pwdata, tb_byte, att} = 56'h0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    begin : run_all
      t_half();
      t_err();
      t_over();
      t_full();
    end
    give_verdict();
  end
endmodule : tx_frame_statistics_reporter_tb
